// [hw/fast_mux_pkg.sv]
/*
  Constants for the fast-filter result and input multiplexer registers.
  Assumes an 8-bit special function register bus with byte addresses.
*/
//
// Operation
// - 24-bit variant: high byte shows result bits 23 to 16.
// - 24-bit variant: middle byte shows result bits 15 to 8.
// - 24-bit variant: low byte shows result bits 7 to 0.
// - 16-bit variant: high byte shows result bits 15 to 8.
// - 16-bit variant: middle byte shows result bits 7 to 0.
// - 16-bit variant: low byte always reads zero.
// - Upper nibble selects positive input; 0-7 external, 15 temperature.
// - Lower nibble selects negative input with the same encoding.
// - Any other code connects that converter input to analog ground.
// - Positive and negative inputs are selected independently.
// - Selecting the temperature sensor on either input enables it.
// - A read-only busy flag shows a conversion in progress.
package fast_mux_pkg;
  localparam logic [7:0] addr_input_mux_select   = 8'hc6;
  localparam logic [7:0] addr_fast_result_high   = 8'hfe;
  localparam logic [7:0] addr_fast_result_middle = 8'hfd;
  localparam logic [7:0] addr_fast_result_low    = 8'hfc;
  localparam logic [7:0] addr_converter_status   = 8'he8;
  localparam logic [7:0] reset_input_mux_select  = 8'h00;
  localparam logic [7:0] reset_fast_result       = 8'h00;
  localparam int         pos_sel_lsb             = 4;
  localparam int         sel_width               = 4;
  localparam int         busy_bit                = 7;
  localparam logic [3:0] sel_last_external       = 4'h7;
  localparam logic [3:0] sel_temperature         = 4'hf;
endpackage

// [hw/input_select_decode.sv]
/*
  Decodes one 4-bit input select code to a one-hot route.
  Assumes the code comes from a register on the same clock.
*/
`timescale 1ns/1ns
module input_select_decode (
  input  wire logic [3:0] code,
  output logic      [7:0] external_onehot,
  output logic            temperature,
  output logic            ground
);
  always_comb begin
    external_onehot = 8'h00;
    temperature     = 1'b0;
    ground          = 1'b0;
    if (code <= fast_mux_pkg::sel_last_external) begin
      external_onehot[code[2:0]] = 1'b1;
    end else if (code == fast_mux_pkg::sel_temperature) begin
      temperature = 1'b1;
    end else begin
      ground = 1'b1;
    end
  end
endmodule

// [hw/fast_mux_regs.sv]
/*
  Fast-filter result bytes, input multiplexer control and busy flag.
  Assumes a core bus with one-cycle write strobe and registered read data.
*/
`timescale 1ns/1ns
module fast_mux_regs #(
  parameter bit wide_result = 1'b1
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_write,
  input  wire logic        sfr_read,
  output logic      [7:0]  sfr_rdata,
  input  wire logic [23:0] fast_result,
  input  wire logic        result_valid,
  input  wire logic        conversion_active,
  output logic      [7:0]  positive_external_select,
  output logic             positive_temperature_select,
  output logic             positive_ground_select,
  output logic      [7:0]  negative_external_select,
  output logic             negative_temperature_select,
  output logic             negative_ground_select,
  output logic             temperature_sensor_enable,
  output logic             conversion_in_progress_flag
);
  logic [7:0] input_mux_select;
  logic [7:0] fast_result_high;
  logic [7:0] fast_result_middle;
  logic [7:0] fast_result_low;
  logic [7:0] next_rdata;
  logic [7:0] pos_ext;
  logic [7:0] neg_ext;
  logic       pos_temp;
  logic       neg_temp;
  logic       pos_gnd;
  logic       neg_gnd;

  // Software writes the mux at will; keeping it idle is the caller's job.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      input_mux_select <= fast_mux_pkg::reset_input_mux_select;
    end else if (sfr_write &&
                 sfr_addr == fast_mux_pkg::addr_input_mux_select) begin
      input_mux_select <= sfr_wdata;
    end
  end

  // All three bytes load in the same cycle; the 16-bit variant loads the low byte with zero.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fast_result_high   <= fast_mux_pkg::reset_fast_result;
      fast_result_middle <= fast_mux_pkg::reset_fast_result;
      fast_result_low    <= fast_mux_pkg::reset_fast_result;
    end else if (result_valid) begin
      if (wide_result) begin
        fast_result_high   <= fast_result[23:16];
        fast_result_middle <= fast_result[15:8];
        fast_result_low    <= fast_result[7:0];
      end else begin
        fast_result_high   <= fast_result[15:8];
        fast_result_middle <= fast_result[7:0];
        fast_result_low    <= fast_mux_pkg::reset_fast_result;
      end
    end
  end

  // Each field drives its own decoder, so both inputs are independent.
  input_select_decode positive_decode (
    .code            (input_mux_select[fast_mux_pkg::pos_sel_lsb +:
                                       fast_mux_pkg::sel_width]),
    .external_onehot (pos_ext),
    .temperature     (pos_temp),
    .ground          (pos_gnd)
  );
  input_select_decode negative_decode (
    .code            (input_mux_select[fast_mux_pkg::sel_width-1:0]),
    .external_onehot (neg_ext),
    .temperature     (neg_temp),
    .ground          (neg_gnd)
  );

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      positive_external_select    <= 8'h00;
      positive_temperature_select <= 1'b0;
      positive_ground_select      <= 1'b0;
      negative_external_select    <= 8'h00;
      negative_temperature_select <= 1'b0;
      negative_ground_select      <= 1'b0;
      temperature_sensor_enable   <= 1'b0;
    end else begin
      positive_external_select    <= pos_ext;
      positive_temperature_select <= pos_temp;
      positive_ground_select      <= pos_gnd;
      negative_external_select    <= neg_ext;
      negative_temperature_select <= neg_temp;
      negative_ground_select      <= neg_gnd;
      temperature_sensor_enable   <= pos_temp | neg_temp;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      conversion_in_progress_flag <= 1'b0;
    end else begin
      conversion_in_progress_flag <= conversion_active;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    unique case (sfr_addr)
      fast_mux_pkg::addr_input_mux_select:   next_rdata = input_mux_select;
      fast_mux_pkg::addr_fast_result_high:   next_rdata = fast_result_high;
      fast_mux_pkg::addr_fast_result_middle: next_rdata = fast_result_middle;
      fast_mux_pkg::addr_fast_result_low:    next_rdata = fast_result_low;
      fast_mux_pkg::addr_converter_status: begin
        next_rdata[fast_mux_pkg::busy_bit] = conversion_in_progress_flag;
      end
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_read) begin
      sfr_rdata <= next_rdata;
    end
  end
endmodule

// [bench/fast_mux_regs_props.sv]
/* Port assertions for fast_mux_regs; assumes one clock, mclk. */
`timescale 1ns/1ns
module fast_mux_regs_props #(parameter bit wide_result = 1'h1) (
  input wire logic mclk, rstn, sfr_write, sfr_read, result_valid,
  input wire logic conversion_active, conversion_in_progress_flag,
  input wire logic positive_temperature_select, positive_ground_select,
  input wire logic negative_temperature_select, negative_ground_select,
  input wire logic temperature_sensor_enable,
  input wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata,
  input wire logic [7:0] positive_external_select, negative_external_select,
  input wire logic [23:0] fast_result);
  logic [23:0] h;
  let rd(a) = sfr_read && sfr_addr == a && !result_valid;
  let wm = sfr_write && sfr_addr == 8'hc6;
  function automatic logic [9:0] dec(logic [3:0] c);
    return {c == 4'hf, c > 4'h7 && c < 4'hf, c < 4'h8 ? 8'h01 << c : 8'h00};
  endfunction
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn) h <= '0;
    else if (result_valid) h <= fast_result;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_hi; rd(8'hfe) |=>
    sfr_rdata == (wide_result ? h[23:16] : h[15:8]); endproperty
  a_hi: assert property (p_hi) else $error("high byte");
  property p_md; rd(8'hfd) |=>
    sfr_rdata == (wide_result ? h[15:8] : h[7:0]); endproperty
  a_md: assert property (p_md) else $error("middle byte");
  property p_lo; rd(8'hfc) |=>
    sfr_rdata == (wide_result ? h[7:0] : 8'h00); endproperty
  a_lo: assert property (p_lo) else $error("low byte");
  property p_pos; wm |-> ##2 {positive_temperature_select,
    positive_ground_select, positive_external_select} ==
    dec($past(sfr_wdata[7:4], 2)); endproperty
  a_pos: assert property (p_pos) else $error("positive route");
  property p_neg; wm |-> ##2 {negative_temperature_select,
    negative_ground_select, negative_external_select} ==
    dec($past(sfr_wdata[3:0], 2)); endproperty
  a_neg: assert property (p_neg) else $error("negative route");
  property p_ts; temperature_sensor_enable ==
    (positive_temperature_select || negative_temperature_select); endproperty
  a_ts: assert property (p_ts) else $error("sensor enable");
  property p_fl; $past(rstn) |->
    conversion_in_progress_flag == $past(conversion_active); endproperty
  a_fl: assert property (p_fl) else $error("busy flag");
  property p_st; rd(8'he8) |=>
    sfr_rdata == {$past(conversion_in_progress_flag), 7'h00}; endproperty
  a_st: assert property (p_st) else $error("status read");
  c_tmp: cover property (wm && sfr_wdata[7:4] == 4'hf);
  c_hi: cover property (rd(8'hfe));
  c_ld: cover property (result_valid);
endmodule
bind fast_mux_regs fast_mux_regs_props #(.wide_result(wide_result)) u_p (.*);

// [bench/tb_fast_mux_regs.sv]
/* Bench for fast_mux_regs; drives its ports directly. */
`timescale 1ns/1ns
module tb_fast_mux_regs;
  logic mclk = '0, rstn = '0, sfr_write = '0, sfr_read = '0;
  logic result_valid = '0, conversion_active = '0, temperature_sensor_enable;
  logic positive_temperature_select, positive_ground_select;
  logic negative_temperature_select, negative_ground_select;
  logic conversion_in_progress_flag;
  logic [7:0] sfr_addr = '0, sfr_wdata = '0, sfr_rdata, q;
  logic [7:0] positive_external_select, negative_external_select;
  logic [23:0] fast_result = '0, r;
  int error_cnt = 0, n_checks = 0, seed = 32'hb5d63889;
  logic [7:0] rdata_n;
  fast_mux_regs u_fast_mux_regs (.*);
  fast_mux_regs #(.wide_result(1'b0)) u_fast_mux_regs_narrow (
    .*,
    .sfr_rdata                   (rdata_n),
    .positive_external_select    (),
    .positive_temperature_select (),
    .positive_ground_select      (),
    .negative_external_select    (),
    .negative_temperature_select (),
    .negative_ground_select      (),
    .temperature_sensor_enable   (),
    .conversion_in_progress_flag ()
  );
  initial forever #50 mclk = ~mclk;
  task stop_test;
    if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task check(input string name, input logic [9:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [9:0] route(logic [3:0] c);
    int n;
    n = c;
    return {n == 15, n > 7 && n < 15, n < 8 ? 8'(1 << n) : 8'h00};
  endfunction
  task acc(logic [7:0] a, v, vn, logic w = '0);
    @(posedge mclk);
    sfr_addr <= a;
    sfr_wdata <= v;
    sfr_write <= w;
    sfr_read <= !w;
    @(posedge mclk);
    sfr_write <= '0;
    sfr_read <= '0;
    @(negedge mclk);
    if (!w) begin
      check("wide read", sfr_rdata, v);
      check("narrow read", rdata_n, vn);
    end
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rstn <= '1;
    for (int i = 0; i < 16; i++) begin
      q = {i[3:0], ~i[3:0]};
      acc(8'hc6, q, q, '1);
      acc(8'hc6, q, q);
      check("positive route", {positive_temperature_select,
            positive_ground_select, positive_external_select},
            route(q[7:4]));
      check("negative route", {negative_temperature_select,
            negative_ground_select, negative_external_select},
            route(q[3:0]));
      check("sensor enable", temperature_sensor_enable,
            q[7:4] == 4'hf || q[3:0] == 4'hf);
    end
    repeat (4) begin
      r = $random(seed);
      @(posedge mclk);
      fast_result <= r;
      result_valid <= '1;
      conversion_active <= r[0];
      @(posedge mclk);
      result_valid <= '0;
      fast_result <= ~r;
      acc(8'hfe, 8'h5a, 8'h5a, '1);
      acc(8'hfe, r[23:16], r[15:8]);
      acc(8'hfd, r[15:8], r[7:0]);
      acc(8'hfc, r[7:0], 8'h00);
      acc(8'he8, {r[0], 7'h00}, {r[0], 7'h00});
      check("busy flag", conversion_in_progress_flag, r[0]);
    end
    stop_test;
  end
endmodule
